// *** design/ddrdqs_defs.svh ***
`ifndef DDRDQS_DEFS_SVH
`define DDRDQS_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define DDRDQS_OFF_CTRL 12'h000
`define DDRDQS_OFF_INV 12'h004
`define DDRDQS_OFF_STAT 12'h008
`define DDRDQS_OFF_CNT 12'h00C

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define DDRDQS_CTRL_MODE_LSB 0
`define DDRDQS_CTRL_MODE_MSB 1
`define DDRDQS_CTRL_OD 2
`define DDRDQS_CTRL_PLL_T 3
`define DDRDQS_CTRL_PIN_T_LSB 4
`define DDRDQS_CTRL_PIN_T_MSB 5
`define DDRDQS_CTRL_SIDE 6
`define DDRDQS_CTRL_BIDIR 7
`define DDRDQS_CTRL_PLL_B 8
`define DDRDQS_CTRL_PIN_B_LSB 9
`define DDRDQS_CTRL_PIN_B_MSB 10
`define DDRDQS_CTRL_RST 11'h080

// ---------------------------------------------------------------
// inversion fields
// ---------------------------------------------------------------
`define DDRDQS_INV_DQ 0
`define DDRDQS_INV_DQS 1
`define DDRDQS_INV_DA 2
`define DDRDQS_INV_DB 3
`define DDRDQS_INV_OE 4
`define DDRDQS_INV_RST 5'h00

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define DDRDQS_STAT_CODE_T_LSB 0
`define DDRDQS_STAT_CODE_B_LSB 8
`define DDRDQS_STAT_LOCK_T 16
`define DDRDQS_STAT_LOCK_B 17
`define DDRDQS_STAT_RIGHT 18

// ---------------------------------------------------------------
// group widths, strobe pair limits, reference measurement
// ---------------------------------------------------------------
`define DDRDQS_W_X4 6'h04
`define DDRDQS_W_X9 6'h09
`define DDRDQS_W_X18 6'h12
`define DDRDQS_W_X36 6'h24
`define DDRDQS_MAX_PAIRS 18
`define DDRDQS_RIGHT_PAIRS 10
`define DDRDQS_LEFT_PAIRS 8
`define DDRDQS_REF_EDGES 5'h10
`define DDRDQS_REF_SHIFT 2

`endif

// *** design/ddrdqs_pkg.sv ***
package ddrdqs_pkg;
    typedef enum logic [1:0] {DDRDQS_X4, DDRDQS_X9, DDRDQS_X18, DDRDQS_X36} ddrdqs_width_e;
    typedef enum logic [0:0] {MEAS_IDLE, MEAS_RUN} ddrdqs_meas_e;
endpackage

// *** design/ddrdqs_cell_top.sv ***
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ddrdqs_defs.svh"

// Overview of operation
// - the cell offers a bidirectional double-rate mode joining the input capture and output paths on one pin.
// - in bidirectional mode the output-enable register is clocked on the falling edge so the enable waits for it.
// - the pin driver enable is active low, so the active-high enable request is inverted before its register.
// - every input into the cell (data in, strobe, both output bits, enable) can be inverted by configuration.
// - memory groups are selectable as by-4, by-8/9, by-16/18 or by-32/36 wide.
// - each strobe passes a compensated delay whose setting centres it in the data window.
// - the delayed strobe forms a local strobe bus, apart from the I/O clock, that clocks the data capture registers.
// - a top and a bottom phase-shift reference each set the delay of the strobes on their own edge.
// - each reference is taken from a dedicated clock pin group of its side or from a PLL output.
// - only one designated PLL may feed the top reference and only another designated one the bottom.
// - each edge holds up to 18 strobe pairs, up to 10 right of the reference and up to 8 left of it.
// - each pin can work as an open-drain output for shared wired control lines.
// - double-rate input uses registers on both strobe edges plus a third falling-edge register so both bits align to one edge.
// - double-rate output loads two registers on the rising edge and the clock muxes bit one high, bit two low.
module ddrdqs_cell_top
    import ddrdqs_pkg::*;
#(
    parameter int DQ_W = 36,
    parameter int PAIR_IDX = 0
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W-1:0] dq_oe,
    input wire logic dqs_in,
    input wire logic [3:0] ref_pin_top,
    input wire logic [3:0] ref_pin_bot,
    input wire logic pll_top_clk,
    input wire logic pll_bot_clk,
    input wire logic [DQ_W-1:0] wr_data_a,
    input wire logic [DQ_W-1:0] wr_data_b,
    input wire logic wr_oe,
    output logic [DQ_W-1:0] rd_data_hi,
    output logic [DQ_W-1:0] rd_data_lo,
    output logic rd_valid,
    output logic [7:0] dqs_delay_code
);

    // -----------------------------------------------------------
    // reset release
    // -----------------------------------------------------------
    logic rst_s1_reg;
    logic rst_sync_n;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    // -----------------------------------------------------------
    // apb slave, zero wait states
    // -----------------------------------------------------------
    logic [10:0] ctrl_reg;
    logic [4:0] inv_reg;
    logic [15:0] cap_cnt_reg;
    logic [31:0] stat_word;
    logic [1:0] side_lock;
    logic [7:0] side_code [2];
    logic err_reg;
    logic wr_acc;

    assign pready = 1'b1;
    assign pslverr = psel & penable & err_reg;
    assign wr_acc = psel & penable & pwrite;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ctrl_reg <= `DDRDQS_CTRL_RST;
        else if (wr_acc && paddr == `DDRDQS_OFF_CTRL)
            ctrl_reg <= pwdata[10:0];
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            inv_reg <= `DDRDQS_INV_RST;
        else if (wr_acc && paddr == `DDRDQS_OFF_INV)
            inv_reg <= pwdata[4:0];
    end

    // a strobe pair to the right of the reference sits below this index
    localparam logic PAIR_RIGHT = (PAIR_IDX < `DDRDQS_RIGHT_PAIRS);

    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[`DDRDQS_STAT_CODE_T_LSB +: 8] = side_code[0];
        stat_word[`DDRDQS_STAT_CODE_B_LSB +: 8] = side_code[1];
        stat_word[`DDRDQS_STAT_LOCK_T] = side_lock[0];
        stat_word[`DDRDQS_STAT_LOCK_B] = side_lock[1];
        stat_word[`DDRDQS_STAT_RIGHT] = PAIR_RIGHT;
    end

    // read data is fetched in the setup cycle so it comes from a flop
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            prdata <= 32'h0000_0000;
            err_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            err_reg <= 1'b0;
            case (paddr)
                `DDRDQS_OFF_CTRL: prdata <= {21'h000000, ctrl_reg};
                `DDRDQS_OFF_INV: prdata <= {27'h0000000, inv_reg};
                `DDRDQS_OFF_STAT: prdata <= stat_word;
                `DDRDQS_OFF_CNT: prdata <= {16'h0000, cap_cnt_reg};
                default:
                begin
                    prdata <= 32'h0000_0000;
                    err_reg <= 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // group width
    // -----------------------------------------------------------
    ddrdqs_width_e width_mode;
    logic [5:0] act_w;
    logic [DQ_W-1:0] act_mask;

    assign width_mode = ddrdqs_width_e'(ctrl_reg[`DDRDQS_CTRL_MODE_MSB:`DDRDQS_CTRL_MODE_LSB]);

    always_comb
    begin
        case (width_mode)
            DDRDQS_X4: act_w = `DDRDQS_W_X4;
            DDRDQS_X9: act_w = `DDRDQS_W_X9;
            DDRDQS_X18: act_w = `DDRDQS_W_X18;
            DDRDQS_X36: act_w = `DDRDQS_W_X36;
            default: act_w = `DDRDQS_W_X4;
        endcase
    end

    // -----------------------------------------------------------
    // double-rate output and enable
    // -----------------------------------------------------------
    logic [DQ_W-1:0] out_a_reg;
    logic [DQ_W-1:0] out_b_reg;
    logic [DQ_W-1:0] pin_val;
    logic oe_n_neg_reg;
    logic oe_n_pos_reg;
    logic oe_n;
    logic od_mode;

    assign od_mode = ctrl_reg[`DDRDQS_CTRL_OD];

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            out_a_reg <= '0;
            out_b_reg <= '0;
        end
        else
        begin
            out_a_reg <= wr_data_a ^ {DQ_W{inv_reg[`DDRDQS_INV_DA]}};
            out_b_reg <= wr_data_b ^ {DQ_W{inv_reg[`DDRDQS_INV_DB]}};
        end
    end

    // first bit while the clock is high, second while it is low
    assign pin_val = clk_sys ? out_a_reg : out_b_reg;

    // enable registers hold the active-low driver control; reset releases the pin
    // the falling-edge copy follows the rising-edge one, so a new enable
    // reaches the pin half a cycle later and the memory can turn the bus round
    always_ff @(negedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            oe_n_neg_reg <= 1'b1;
        else
            oe_n_neg_reg <= oe_n_pos_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            oe_n_pos_reg <= 1'b1;
        else
            oe_n_pos_reg <= ~(wr_oe ^ inv_reg[`DDRDQS_INV_OE]);
    end

    // turnaround: bidirectional mode keeps the driver off until the falling edge
    assign oe_n = ctrl_reg[`DDRDQS_CTRL_BIDIR] ? oe_n_neg_reg : oe_n_pos_reg;

    genvar gi;
    generate
        for (gi = 0; gi < DQ_W; gi++)
        begin : g_bit
            assign act_mask[gi] = (6'(gi) < act_w);
            // open drain pulls low only; a high value floats the line
            assign dq_oe[gi] = act_mask[gi] & ~oe_n & (~od_mode | ~pin_val[gi]);
            assign dq_out[gi] = od_mode ? 1'b0 : pin_val[gi];
        end
    endgenerate

    // -----------------------------------------------------------
    // strobe-clocked capture
    // -----------------------------------------------------------
    // inversion and width settings are quasi-static towards the strobe
    // domain; change them only while the strobe is idle
    logic dqs_bus;
    logic [DQ_W-1:0] dq_int;
    logic [DQ_W-1:0] hi_reg;
    logic [DQ_W-1:0] hi_lat_reg;
    logic [DQ_W-1:0] lo_reg;
    logic cap_tog_reg;

    // the strobe delay line sits at the pad, steered by dqs_delay_code
    assign dqs_bus = dqs_in ^ inv_reg[`DDRDQS_INV_DQS];
    assign dq_int = (dq_in ^ {DQ_W{inv_reg[`DDRDQS_INV_DQ]}}) & act_mask;

    always_ff @(posedge dqs_bus or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            hi_reg <= '0;
        else
            hi_reg <= dq_int;
    end

    always_ff @(negedge dqs_bus or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            lo_reg <= '0;
            hi_lat_reg <= '0;
            cap_tog_reg <= 1'b0;
        end
        else
        begin
            lo_reg <= dq_int;
            hi_lat_reg <= hi_reg;
            cap_tog_reg <= ~cap_tog_reg;
        end
    end

    // -----------------------------------------------------------
    // word crossing into the system clock
    // -----------------------------------------------------------
    // limitation: the word is held only one strobe period, so the strobe
    // period must exceed three system clocks
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic word_evt;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end
        else
        begin
            tog_s1_reg <= cap_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    assign word_evt = tog_s2_reg ^ tog_s3_reg;

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rd_data_hi <= '0;
            rd_data_lo <= '0;
            rd_valid <= 1'b0;
            cap_cnt_reg <= 16'h0000;
        end
        else
        begin
            rd_valid <= word_evt;
            if (word_evt)
            begin
                rd_data_hi <= hi_lat_reg;
                rd_data_lo <= lo_reg;
                cap_cnt_reg <= cap_cnt_reg + 16'h0001;
            end
        end
    end

    // -----------------------------------------------------------
    // phase-shift references, top (0) and bottom (1)
    // -----------------------------------------------------------
    // the code is a quarter reference period in sixteenths of a system
    // clock, taken over sixteen reference periods
    logic [1:0] ref_src;
    // each side has a single wired PLL input; no other PLL can reach it
    assign ref_src[0] = ctrl_reg[`DDRDQS_CTRL_PLL_T] ? pll_top_clk :
        ref_pin_top[ctrl_reg[`DDRDQS_CTRL_PIN_T_MSB:`DDRDQS_CTRL_PIN_T_LSB]];
    assign ref_src[1] = ctrl_reg[`DDRDQS_CTRL_PLL_B] ? pll_bot_clk :
        ref_pin_bot[ctrl_reg[`DDRDQS_CTRL_PIN_B_MSB:`DDRDQS_CTRL_PIN_B_LSB]];

    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++)
        begin : g_side
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic rise;
            ddrdqs_meas_e st_reg;
            logic [9:0] cyc_reg;
            logic [4:0] edges_reg;
            logic [7:0] code_reg;
            logic lock_reg;
            logic [7:0] code_next;

            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= ref_src[gs];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end

            assign rise = s2_reg & ~s3_reg;
            assign code_next = 8'((cyc_reg + 10'h001) >> `DDRDQS_REF_SHIFT);

            always_ff @(posedge clk_sys or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                begin
                    st_reg <= MEAS_IDLE;
                    cyc_reg <= '0;
                    edges_reg <= '0;
                    code_reg <= 8'h00;
                    lock_reg <= 1'b0;
                end
                else
                begin
                    case (st_reg)
                        MEAS_IDLE:
                        begin
                            cyc_reg <= '0;
                            edges_reg <= '0;
                            if (rise)
                                st_reg <= MEAS_RUN;
                        end
                        MEAS_RUN:
                        begin
                            cyc_reg <= cyc_reg + 10'h001;
                            if (rise && edges_reg == `DDRDQS_REF_EDGES - 5'h01)
                            begin
                                code_reg <= code_next;
                                lock_reg <= (code_next == code_reg);
                                cyc_reg <= '0;
                                edges_reg <= '0;
                            end
                            else if (rise)
                                edges_reg <= edges_reg + 5'h01;
                            else if (&cyc_reg)
                            begin
                                // reference stopped: drop lock and rearm
                                lock_reg <= 1'b0;
                                st_reg <= MEAS_IDLE;
                            end
                        end
                        default: st_reg <= MEAS_IDLE;
                    endcase
                end
            end

            assign side_code[gs] = code_reg;
            assign side_lock[gs] = lock_reg;
        end
    endgenerate

    // this strobe takes the setting of the edge it sits on
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            dqs_delay_code <= 8'h00;
        else
            dqs_delay_code <= side_code[ctrl_reg[`DDRDQS_CTRL_SIDE]];
    end

endmodule // ddrdqs_cell_top

`default_nettype wire

// *** sim/ddrdqs_cell_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddrdqs_defs.svh"
module ddrdqs_cell_chk
#(
    parameter int DQ_W = 36
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [DQ_W-1:0] dq_oe,
    input wire logic [DQ_W-1:0] wr_data_a,
    input wire logic [DQ_W-1:0] wr_data_b,
    input wire logic wr_oe,
    input wire logic [DQ_W-1:0] rd_data_hi,
    input wire logic rd_valid
);
    // ----
    // shadow config
    // ----
    logic [10:0] ctrl_reg;
    logic [4:0] inv_reg;
    logic [2:0] quiet_reg;
    logic wr_cfg, od, bi, eo;
    logic [5:0] gw;
    logic [DQ_W-1:0] mask, ea, eb;
    assign wr_cfg = psel && penable && pwrite && paddr[11:3] == 9'h000 && paddr[1:0] == 2'h0;
    assign od = ctrl_reg[`DDRDQS_CTRL_OD];
    assign bi = ctrl_reg[`DDRDQS_CTRL_BIDIR];
    assign gw = ctrl_reg[1] ? (ctrl_reg[0] ? `DDRDQS_W_X36 : `DDRDQS_W_X18)
        : (ctrl_reg[0] ? `DDRDQS_W_X9 : `DDRDQS_W_X4);
    assign mask = ~({DQ_W{1'b1}} << gw);
    assign ea = wr_data_a ^ {DQ_W{inv_reg[`DDRDQS_INV_DA]}};
    assign eb = wr_data_b ^ {DQ_W{inv_reg[`DDRDQS_INV_DB]}};
    assign eo = wr_oe ^ inv_reg[`DDRDQS_INV_OE];
    // output checks wait out the internal reset and any config write, since config is quasi-static
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `DDRDQS_CTRL_RST;
            inv_reg <= `DDRDQS_INV_RST;
            quiet_reg <= 3'h0;
        end
        else
        begin
            if (wr_cfg && !paddr[2])
                ctrl_reg <= pwdata[10:0];
            if (wr_cfg && paddr[2])
                inv_reg <= pwdata[4:0];
            quiet_reg <= wr_cfg ? 3'h0 : (quiet_reg == 3'h7 ? 3'h7 : quiet_reg + 3'h1);
        end
    end
    property p_out_a;
        @(negedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 |-> dq_out == (od ? '0 : $past(ea));
    endproperty
    a_out_a: assert property (p_out_a) else $error("first bit wrong in high phase");
    property p_out_b;
        @(posedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 |-> dq_out == (od ? '0 : $past(eb));
    endproperty
    a_out_b: assert property (p_out_b) else $error("second bit wrong in low phase");
    property p_oe_edge;
        @(negedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 && !od |-> dq_oe[0] == (bi ? $past(eo, 2) : $past(eo));
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("enable not held to falling edge");
    property p_oe_rise;
        @(posedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 && !od |-> dq_oe[0] == $past(eo);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("enable request polarity wrong");
    property p_width;
        @(posedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 |-> (dq_oe & ~mask) == '0;
    endproperty
    a_width: assert property (p_width) else $error("bit beyond group width driven");
    property p_od;
        @(posedge clk_sys) disable iff (!rst_n)
        quiet_reg == 3'h7 && od |-> dq_out == '0 && (dq_oe & $past(eb)) == '0;
    endproperty
    a_od: assert property (p_od) else $error("open drain drove a high value");
    property p_valid;
        @(posedge clk_sys) disable iff (!rst_n)
        rd_valid |=> !rd_valid [*2];
    endproperty
    a_valid: assert property (p_valid) else $error("word valid longer than a pulse");
    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        !rd_valid |-> $stable(rd_data_hi);
    endproperty
    a_hold: assert property (p_hold) else $error("captured word moved without valid");
endmodule // ddrdqs_cell_chk
bind ddrdqs_cell_top ddrdqs_cell_chk #(.DQ_W(DQ_W)) i_ddrdqs_cell_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .dq_out(dq_out), .dq_oe(dq_oe), .wr_data_a(wr_data_a),
    .wr_data_b(wr_data_b), .wr_oe(wr_oe), .rd_data_hi(rd_data_hi), .rd_valid(rd_valid));
`default_nettype wire

// *** sim/ddrdqs_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ddrdqs_mem_model
#(
    parameter int DQ_W = 36
)(
    input wire logic go,
    input wire logic [3:0] n_words,
    input wire logic [DQ_W-1:0] base,
    output logic dqs,
    output logic [DQ_W-1:0] dq
);
    int k;
    // strobe stands low between bursts; data leads each edge by a quarter period
    initial
    begin
        dqs = 1'b0;
        dq = '1;
        forever
        begin
            @(go);
            for (k = 0; k < n_words; k++)
            begin
                dq = base + DQ_W'(2 * k);
                #40 dqs = 1'b1;
                #40 dq = base + DQ_W'(2 * k + 1);
                #40 dqs = 1'b0;
                #40;
            end
            // released bus shows the inverse, never a stale word
            dq = ~dq;
        end
    end
endmodule // ddrdqs_mem_model
`default_nettype wire

// *** sim/ddrdqs_cell_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ddrdqs_defs.svh"
module ddrdqs_cell_tb_top;
    localparam int W = 36;
    logic clk_sys, dqs_in, pready, pslverr, rd_valid, rd_e, pll_bot_clk, cfg_od, cfg_bi;
    logic rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wr_oe = 1'b0;
    logic go = 1'b0, pll_top_clk = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [W-1:0] wr_data_a = '0, wr_data_b = '0, base = '0;
    logic [W-1:0] dq_in, dq_out, dq_oe, rd_data_hi, rd_data_lo, cfg_mask;
    logic [3:0] ref_pin_top = 4'h0, ref_pin_bot = 4'h0, n_words = 4'h0;
    logic [7:0] dqs_delay_code;
    logic [4:0] cfg_inv;
    logic [10:0] ctl_tab [4] = '{11'h080, 11'h001, 11'h006, 11'h083};
    logic [4:0] inv_tab [4] = '{5'h00, 5'h1C, 5'h00, 5'h04};
    logic [5:0] wid_tab [4] = '{`DDRDQS_W_X4, `DDRDQS_W_X9, `DDRDQS_W_X18, `DDRDQS_W_X36};
    int err_count = 0, num_checks = 0, i, s;
    ddrdqs_cell_top #(.DQ_W(W), .PAIR_IDX(0)) i_ddrdqs_cell_top (.clk_sys(clk_sys),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .ref_pin_top(ref_pin_top),
        .ref_pin_bot(ref_pin_bot), .pll_top_clk(pll_top_clk), .pll_bot_clk(pll_bot_clk),
        .wr_data_a(wr_data_a), .wr_data_b(wr_data_b), .wr_oe(wr_oe), .rd_data_hi(rd_data_hi),
        .rd_data_lo(rd_data_lo), .rd_valid(rd_valid), .dqs_delay_code(dqs_delay_code));
    ddrdqs_mem_model #(.DQ_W(W)) i_ddrdqs_mem_model (.go(go), .n_words(n_words),
        .base(base), .dqs(dqs_in), .dq(dq_in));
    // ----
    // clocks: top reference on pin 2 at strobe rate, bottom from its own pll
    // ----
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        #7;
        forever #80 ref_pin_top[2] = ~ref_pin_top[2];
    end
    initial
    begin
        pll_bot_clk = 1'b0;
        #13;
        forever #120 pll_bot_clk = ~pll_bot_clk;
    end
    task chk(input string nm, input logic [W-1:0] exp, input logic [W-1:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task out_step(input logic [W-1:0] a, input logic [W-1:0] b, input logic oe);
        logic [W-1:0] xa, xb, en, en_old;
        xa = a ^ {W{cfg_inv[2]}};
        xb = b ^ {W{cfg_inv[3]}};
        en = cfg_mask & {W{oe ^ cfg_inv[4]}};
        en_old = cfg_mask & {W{wr_oe ^ cfg_inv[4]}};
        @(posedge clk_sys);
        wr_data_a <= a;
        wr_data_b <= b;
        wr_oe <= oe;
        @(posedge clk_sys);
        #10;
        chk("dq_out high", cfg_od ? '0 : xa, dq_out);
        chk("dq_oe high", cfg_bi ? en_old : (cfg_od ? en & ~xa : en), dq_oe);
        @(negedge clk_sys);
        #10;
        chk("dq_out low", cfg_od ? '0 : xb, dq_out);
        chk("dq_oe low", cfg_od ? en & ~xb : en, dq_oe);
    endtask
    task burst(input logic [W-1:0] b0, input logic [3:0] nw, input logic flip);
        int k, n;
        base <= b0;
        n_words <= nw;
        go <= ~go;
        for (k = 0; k < nw; k++)
        begin
            n = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
                n++;
            end while (rd_valid !== 1'b1 && n < 40);
            chk("rd_data_hi", (b0 + W'(2 * k)) ^ {W{flip}}, rd_data_hi);
            chk("rd_data_lo", (b0 + W'(2 * k + 1)) ^ {W{flip}}, rd_data_lo);
        end
    endtask
    task report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, `DDRDQS_OFF_CTRL, 32'h0);
        chk("ctrl reset", W'(`DDRDQS_CTRL_RST), W'(rd_q));
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", W'(2'h3), W'({rd_e, rd_q == 32'h0}));
        for (i = 0; i < 4; i++)
        begin
            cfg_od = ctl_tab[i][2];
            cfg_bi = ctl_tab[i][7];
            cfg_inv = inv_tab[i];
            cfg_mask = ~({W{1'b1}} << wid_tab[ctl_tab[i][1:0]]);
            apb(1'b1, `DDRDQS_OFF_CTRL, 32'(ctl_tab[i]));
            apb(1'b1, `DDRDQS_OFF_INV, 32'(inv_tab[i]));
            for (s = 0; s < 3; s++)
                out_step(36'hF_0F0F_1234 ^ W'(i * 16 + s), 36'h3_C3C3_9876 ^ W'(s), s != 1);
        end
        apb(1'b1, `DDRDQS_OFF_INV, 32'h0);
        burst(36'h1_2345_6780, 4'h3, 1'b0);
        apb(1'b1, `DDRDQS_OFF_INV, 32'h1);
        burst(36'hC_0000_0010, 4'h2, 1'b1);
        apb(1'b1, `DDRDQS_OFF_CNT, 32'hFFFF);
        apb(1'b0, `DDRDQS_OFF_CNT, 32'h0);
        chk("word count", W'(16'h0005), W'(rd_q));
        apb(1'b1, `DDRDQS_OFF_CTRL, 32'h1A0);
        repeat (500) @(posedge clk_sys);
        // a 51.2-cycle window flips the top code between 12 and 13, so top lock
        // comes and goes; poll until both sides report lock
        i = 0;
        do
        begin
            apb(1'b0, `DDRDQS_OFF_STAT, 32'h0);
            i++;
        end while (rd_q[17:16] !== 2'b11 && i < 100);
        // 16 periods of 160 ns is 51 or 52 cycles, a quarter of that is 12 or 13
        chk("top code", W'(1'b1), W'(rd_q[7:0] == 8'h0C || rd_q[7:0] == 8'h0D));
        chk("bottom code", W'(8'h13), W'(rd_q[15:8]));
        chk("locks and pair", W'(3'h7), W'(rd_q[18:16]));
        chk("delay top", W'(1'b1), W'(dqs_delay_code == 8'h0C || dqs_delay_code == 8'h0D));
        apb(1'b1, `DDRDQS_OFF_CTRL, 32'h1E0);
        repeat (3) @(posedge clk_sys);
        chk("delay bottom", W'(8'h13), W'(dqs_delay_code));
        report_and_stop();
    end
    initial
    begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // ddrdqs_cell_tb_top
`default_nettype wire
